/* pkg/bnvtp_pkg.sv */
/*
 * Constants for the bytewide timekeeper port: register map, field
 * positions, write masks, reset values and timing counts.
 * Assumes a 20 MHz system clock and one clock domain.
 */
// Operation
// RQ1 - Read drives addressed byte while strobe high, select and gate low.
// RQ2 - Seventeen address lines pick exactly one register or memory byte.
// RQ3 - Write mode while strobe and select low, address already settled.
// RQ4 - Write cycle starts at later falling edge of select or strobe.
// RQ5 - Write cycle ends at earlier rising edge of select or strobe.
// RQ6 - Host holds the address stable for the whole write cycle.
// RQ7 - Host keeps strobe high a recovery time before the next cycle.
// RQ8 - Byte captured against the terminating rising edge of the write.
// RQ9 - Host should keep output gate high during writes.
// RQ10 - Falling write strobe turns enabled data outputs off.
// RQ11 - Supply out of tolerance blocks writes; bus inputs are don't care.
// RQ12 - Clock, timers and both interrupts keep running without supply.
// RQ13 - Host waits until supply good for 200 ms before accessing.
// RQ14 - Fourteen timekeeping and control registers fill lowest addresses.
// RQ15 - Time and date BCD at 0,1,2,4,6,8,9,A; alarms BCD at 3,5,7.
// RQ16 - Binary command and flag register at B, set by events and writes.
// RQ17 - Watchdog interval BCD in C and D, 0.01 to 99.99 seconds.
// RQ18 - Addresses E to 1FFFF are plain retained user memory bytes.
// RQ19 - Internal time copies transfer to visible copies all at once.
// RQ20 - Date rolls over for short months and leap-year February.
// RQ21 - Hours count in 24-hour or 12-hour format with PM bit.
// RQ22 - Count hundredths to year; alarm reaches times up to one week.
// RQ23 - Transfer-allow bit low freezes visible time copies; high resumes.
// RQ24 - Any watchdog register access reloads countdown and clears flag.
// RQ25 - Both watchdog registers zero disables the watchdog.
// RQ26 - Bus strobes are sampled into the clock domain before acting.
// RQ27 - Supply out of tolerance also ignores reads, data pins undriven.
package bnvtp_pkg;
    localparam int ADDR_W = 17;
    localparam int REG_COUNT = 14;
    localparam logic [3:0] REG_HUNDREDTHS = 4'h0;
    localparam logic [3:0] REG_SECONDS = 4'h1;
    localparam logic [3:0] REG_MINUTES = 4'h2;
    localparam logic [3:0] REG_ALARM_MINUTES = 4'h3;
    localparam logic [3:0] REG_HOURS = 4'h4;
    localparam logic [3:0] REG_ALARM_HOURS = 4'h5;
    localparam logic [3:0] REG_WEEKDAY = 4'h6;
    localparam logic [3:0] REG_ALARM_WEEKDAY = 4'h7;
    localparam logic [3:0] REG_DATE = 4'h8;
    localparam logic [3:0] REG_MONTH = 4'h9;
    localparam logic [3:0] REG_YEAR = 4'ha;
    localparam logic [3:0] REG_CONTROL = 4'hb;
    localparam logic [3:0] REG_WDOG_LO = 4'hc;
    localparam logic [3:0] REG_WDOG_HI = 4'hd;
    // Control register fields
    localparam int CTL_TRANSFER_ALLOW = 7;
    localparam int CTL_IRQ_SWAP = 6;
    localparam int CTL_WDOG_MASK = 3;
    localparam int CTL_ALARM_MASK = 2;
    localparam int CTL_WDOG_FLAG = 1;
    localparam int CTL_ALARM_FLAG = 0;
    localparam logic [7:0] CTL_RESET = 8'hc0;
    // Other fields
    localparam int MONTH_OSC_OFF = 7;
    localparam int HOURS_12H = 6;
    localparam int HOURS_PM = 5;
    localparam int ALARM_MASK_BIT = 7;
    // Writable bits per register, index 0 at the right
    localparam logic [13:0][7:0] REG_WMASK = {
        8'hff, 8'hff, 8'hcc, 8'hff, 8'hdf, 8'h3f, 8'h87,
        8'h07, 8'hff, 8'h7f, 8'hff, 8'h7f, 8'h7f, 8'hff};
    // Time and date registers that have an internal copy
    localparam logic [10:0] TIME_REG_SET = 11'b111_0101_0111;
    // Timing: one hundredth of a second per tick
    localparam int TICK_PERIOD_MS = 10;
    localparam int CLOCK_PERIOD_NS = 50;
    localparam int TICK_CYCLES = (TICK_PERIOD_MS * 1000000) / CLOCK_PERIOD_NS;
    localparam int TICK_CNT_W = 18;
    localparam int WDOG_CNT_W = 14;
endpackage : bnvtp_pkg

/* pkg/bnvtp_mem_if.sv */
/*
 * Carrier between the port logic and the user memory.
 * Assumes both ends share the system clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface bnvtp_mem_if #(
    parameter int ADDR_W = 17
);
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport ctrl (output we, output addr, output wdata, input rdata);
    modport store (input we, input addr, input wdata, output rdata);
endinterface : bnvtp_mem_if
`default_nettype wire

/* rtl/bnvtp_mem.sv */
/*
 * Retained user byte memory, one read or write port, registered read.
 * Assumes the controller never writes in the register window.
 */
`timescale 1ns/100ps
`default_nettype none
module bnvtp_mem
    import bnvtp_pkg::*;
#(
    parameter int ADDR_W = 17
) (
    // Clock
    input wire logic clock,
    input wire logic clock_en,
    // Port
    bnvtp_mem_if.store mem
);
    logic [7:0] store_q [0:(1 << ADDR_W)-1];
    logic [7:0] rdata_q;

    // No reset: contents are meant to survive
    always_ff @(posedge clock) begin
        if (clock_en) begin
            if (mem.we) begin
                store_q[mem.addr] <= mem.wdata; // RQ18
            end
            rdata_q <= store_q[mem.addr];
        end
    end

    assign mem.rdata = rdata_q;
endmodule : bnvtp_mem
`default_nettype wire

/* rtl/bnvtp_top.sv */
/*
 * Bytewide port of a battery-backed timekeeper: sampled asynchronous
 * SRAM-style bus, 14 timekeeping registers, calendar, alarm, watchdog.
 * Assumes bus pins are synchronous to clock, supply_ok comes from an
 * external monitor, and open-drain pins are resolved outside.
 */
`timescale 1ns/100ps
`default_nettype none
module bnvtp_top
    import bnvtp_pkg::*;
#(
    parameter int ADDR_BITS = ADDR_W,
    parameter int TICK_LEN = TICK_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic clock_en,
    // Supply monitor
    input wire logic supply_ok,
    // Bus
    input wire logic select_n,
    input wire logic output_gate_n,
    input wire logic write_strobe_n,
    input wire logic [ADDR_BITS-1:0] address,
    input wire logic [7:0] data_pins_in,
    output logic [7:0] data_pins_out,
    output logic data_pins_oe_n,
    // Open-drain interrupts
    output logic irq_first_n_out,
    output logic irq_first_n_oe_n,
    output logic irq_second_n_out,
    output logic irq_second_n_oe_n
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (ADDR_BITS != ADDR_W) begin : g_bad_addr
        $error("address width must be 17");
    end
    if (TICK_LEN < 2 || TICK_LEN >= (1 << TICK_CNT_W)) begin : g_bad_tick
        $error("tick length out of range");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_READ = 3'b010,
        BUS_WRITE = 3'b100
    } bnvtp_bus_t;

    typedef struct packed {
        bnvtp_bus_t bus_st;
        logic sel_n;
        logic gate_n;
        logic strobe_n;
        logic [ADDR_W-1:0] addr;
        logic [7:0] din;
        logic [ADDR_W-1:0] last_addr;
        logic [ADDR_W-1:0] wr_addr;
        logic [7:0] wr_data;
        logic [13:0][7:0] regs;
        logic [10:0][7:0] intc;
        logic [TICK_CNT_W-1:0] tick_cnt;
        logic [WDOG_CNT_W-1:0] wd_cnt;
        logic alarm_flag;
        logic wd_flag;
        logic [7:0] dout;
        logic dout_oe_n;
        logic irq_a;
        logic irq_b;
    } bnvtp_state_t;

    localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_LEN - 1);

    bnvtp_state_t s;
    bnvtp_state_t next_s;
    bnvtp_mem_if #(.ADDR_W(ADDR_W)) mem ();

    logic act_wr;
    logic act_rd;
    logic rd_ev;
    logic wr_ev;
    logic tick;
    logic sec_roll;
    logic day_roll;
    logic alarm_hit;
    logic wd_en;
    logic wd_access;
    logic alarm_access;
    logic [3:0] acc_idx;
    logic acc_is_reg;
    logic [3:0] wr_idx;
    logic [7:0] wr_val;
    logic [10:0][7:0] t;
    logic [WDOG_CNT_W-1:0] wd_reload;
    logic alarm_act;
    logic wd_act;

    // ------------------------------------------------------------
    // Arithmetic helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            return {v[7:4] + 4'h1, 4'h0};
        end
        return {v[7:4], v[3:0] + 4'h1};
    endfunction : bcd_inc

    function automatic logic [6:0] bcd2bin(input logic [7:0] v);
        return 7'(v[7:4]) * 7'd10 + 7'(v[3:0]);
    endfunction : bcd2bin

    function automatic logic [7:0] days_in_month(input logic [4:0] mon,
                                                 input logic [7:0] yr);
        logic [6:0] y;
        y = bcd2bin(yr);
        unique case (mon)
            5'h02: return (y[1:0] == 2'h0) ? 8'h29 : 8'h28;
            5'h04, 5'h06, 5'h09, 5'h11: return 8'h30;
            default: return 8'h31;
        endcase
    endfunction : days_in_month

    function automatic logic [7:0] hour_inc(input logic [7:0] h);
        if (h[HOURS_12H]) begin
            if (h[4:0] == 5'h12) begin
                return {h[7:5], 5'h01};
            end
            if (h[4:0] == 5'h11) begin
                return {h[7:6], ~h[HOURS_PM], 5'h12};
            end
            return {h[7:5], 5'(bcd_inc({3'h0, h[4:0]}))};
        end
        if (h[5:0] == 6'h23) begin
            return {h[7:6], 6'h00};
        end
        return {h[7:6], 6'h00} | (bcd_inc({2'h0, h[5:0]}) & 8'h3f);
    endfunction : hour_inc

    function automatic logic [7:0] reg_read(input bnvtp_state_t st,
                                            input logic [3:0] idx);
        logic [7:0] v;
        v = st.regs[idx];
        if (idx == REG_CONTROL) begin // RQ16
            v[CTL_WDOG_FLAG] = st.wd_flag;
            v[CTL_ALARM_FLAG] = st.alarm_flag;
        end
        return v;
    endfunction : reg_read

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        rd_ev = 1'b0;
        wr_ev = 1'b0;
        sec_roll = 1'b0;
        day_roll = 1'b0;
        t = s.intc;

        // Pins sampled once before any decision
        next_s.sel_n = select_n; // RQ26
        next_s.gate_n = output_gate_n; // RQ26
        next_s.strobe_n = write_strobe_n; // RQ26
        next_s.addr = address;
        next_s.din = data_pins_in;
        next_s.last_addr = s.addr;

        act_wr = supply_ok && !s.sel_n && !s.strobe_n; // RQ3 RQ11
        act_rd = supply_ok && !s.sel_n && !s.gate_n && s.strobe_n; // RQ1 RQ27

        unique case (s.bus_st)
            BUS_IDLE: begin
                if (act_wr) begin // RQ4
                    next_s.bus_st = BUS_WRITE;
                    next_s.wr_addr = s.addr;
                    next_s.wr_data = s.din;
                end else if (act_rd) begin
                    next_s.bus_st = BUS_READ;
                    rd_ev = 1'b1;
                end
            end
            BUS_READ: begin
                if (act_wr) begin // RQ10
                    next_s.bus_st = BUS_WRITE;
                    next_s.wr_addr = s.addr;
                    next_s.wr_data = s.din;
                end else if (!act_rd) begin
                    next_s.bus_st = BUS_IDLE;
                end else if (s.addr != s.last_addr) begin
                    rd_ev = 1'b1;
                end
            end
            BUS_WRITE: begin
                if (!supply_ok) begin
                    next_s.bus_st = BUS_IDLE; // RQ11
                end else if (!act_wr) begin
                    // Data held from before the rising edge is committed
                    next_s.bus_st = BUS_IDLE; // RQ5
                    wr_ev = 1'b1; // RQ8
                end else begin
                    next_s.wr_data = s.din; // RQ8
                end
            end
            default: begin
                next_s.bus_st = BUS_IDLE;
            end
        endcase

        // Read data path, one cycle behind the address
        next_s.dout_oe_n = !(s.bus_st == BUS_READ && act_rd); // RQ1 RQ10 RQ27
        if (s.last_addr < ADDR_W'(REG_COUNT)) begin // RQ2 RQ14
            next_s.dout = reg_read(s, s.last_addr[3:0]);
        end else begin
            next_s.dout = mem.rdata; // RQ18
        end

        // Hundredths tick, runs regardless of supply
        tick = (s.tick_cnt == TICK_LAST); // RQ12
        next_s.tick_cnt = tick ? '0 : s.tick_cnt + 1'b1;

        if (tick && !s.regs[REG_MONTH][MONTH_OSC_OFF]) begin // RQ22
            if (t[REG_HUNDREDTHS] == 8'h99) begin
                t[REG_HUNDREDTHS] = 8'h00;
                if (t[REG_SECONDS] == 8'h59) begin
                    t[REG_SECONDS] = 8'h00;
                    sec_roll = 1'b1;
                    if (t[REG_MINUTES] == 8'h59) begin
                        t[REG_MINUTES] = 8'h00;
                        day_roll = t[REG_HOURS][HOURS_12H] ? // RQ21
                            (t[REG_HOURS][5:0] == 6'h31) : (t[REG_HOURS][5:0] == 6'h23);
                        t[REG_HOURS] = hour_inc(t[REG_HOURS]); // RQ21
                    end else begin
                        t[REG_MINUTES] = bcd_inc(t[REG_MINUTES]);
                    end
                end else begin
                    t[REG_SECONDS] = bcd_inc(t[REG_SECONDS]);
                end
            end else begin
                t[REG_HUNDREDTHS] = bcd_inc(t[REG_HUNDREDTHS]);
            end
            if (day_roll) begin
                t[REG_WEEKDAY] = (t[REG_WEEKDAY] == 8'h07) ? 8'h01 : bcd_inc(t[REG_WEEKDAY]);
                if (t[REG_DATE] == days_in_month(t[REG_MONTH][4:0], t[REG_YEAR])) begin // RQ20
                    t[REG_DATE] = 8'h01;
                    if (t[REG_MONTH][4:0] == 5'h12) begin
                        t[REG_MONTH][4:0] = 5'h01;
                        t[REG_YEAR] = (t[REG_YEAR] == 8'h99) ? 8'h00 : bcd_inc(t[REG_YEAR]);
                    end else begin
                        t[REG_MONTH][4:0] = 5'(bcd_inc({3'h0, t[REG_MONTH][4:0]}));
                    end
                end else begin
                    t[REG_DATE] = bcd_inc(t[REG_DATE]);
                end
            end
            next_s.intc = t;
            // All incremented values become visible together
            if (s.regs[REG_CONTROL][CTL_TRANSFER_ALLOW]) begin // RQ23
                for (int i = 0; i < 11; i++) begin
                    if (TIME_REG_SET[i]) begin
                        next_s.regs[i] = t[i]; // RQ19
                    end
                end
            end
        end

        // Weekly alarm: a mask bit turns its field into a wildcard
        alarm_hit = sec_roll
            && (s.regs[REG_ALARM_MINUTES][ALARM_MASK_BIT]
                || s.regs[REG_ALARM_MINUTES][6:0] == t[REG_MINUTES][6:0])
            && (s.regs[REG_ALARM_HOURS][ALARM_MASK_BIT]
                || s.regs[REG_ALARM_HOURS][6:0] == t[REG_HOURS][6:0])
            && (s.regs[REG_ALARM_WEEKDAY][ALARM_MASK_BIT]
                || s.regs[REG_ALARM_WEEKDAY][2:0] == t[REG_WEEKDAY][2:0]); // RQ22

        // Host write, after the tick so the host value wins
        wr_idx = s.wr_addr[3:0];
        wr_val = s.wr_data & REG_WMASK[wr_idx]; // RQ15 RQ16 RQ17
        if (wr_ev && s.wr_addr < ADDR_W'(REG_COUNT)) begin // RQ2 RQ14
            next_s.regs[wr_idx] = wr_val;
            if (wr_idx < 4'hb && TIME_REG_SET[wr_idx]) begin
                next_s.intc[wr_idx] = wr_val; // RQ19
            end
        end

        // Side effects of an access of either kind
        acc_idx = wr_ev ? s.wr_addr[3:0] : s.addr[3:0];
        acc_is_reg = wr_ev ? (s.wr_addr < ADDR_W'(REG_COUNT)) : (s.addr < ADDR_W'(REG_COUNT));
        wd_access = (rd_ev || wr_ev) && acc_is_reg
            && (acc_idx == REG_WDOG_LO || acc_idx == REG_WDOG_HI); // RQ24
        alarm_access = (rd_ev || wr_ev) && acc_is_reg
            && (acc_idx == REG_ALARM_MINUTES || acc_idx == REG_ALARM_HOURS
                || acc_idx == REG_ALARM_WEEKDAY);

        // Watchdog countdown in hundredths
        wd_reload = WDOG_CNT_W'(bcd2bin(next_s.regs[REG_WDOG_HI])) * WDOG_CNT_W'(100)
            + WDOG_CNT_W'(bcd2bin(next_s.regs[REG_WDOG_LO])); // RQ17
        wd_en = (wd_reload != '0); // RQ25
        if (wd_access || !wd_en) begin
            next_s.wd_cnt = wd_reload; // RQ24
        end else if (tick) begin // RQ12
            next_s.wd_cnt = (s.wd_cnt <= WDOG_CNT_W'(1)) ? wd_reload : s.wd_cnt - 1'b1;
        end

        // Clears first, so a same-cycle alarm still sets its flag; a watchdog access blocks a same-cycle expiry
        if (alarm_access) begin
            next_s.alarm_flag = 1'b0;
        end
        if (wd_access) begin
            next_s.wd_flag = 1'b0; // RQ24
        end
        if (alarm_hit) begin
            next_s.alarm_flag = 1'b1; // RQ16
        end
        if (tick && wd_en && !wd_access && s.wd_cnt <= WDOG_CNT_W'(1)) begin
            next_s.wd_flag = 1'b1; // RQ16 RQ25
        end

        alarm_act = next_s.alarm_flag && !next_s.regs[REG_CONTROL][CTL_ALARM_MASK];
        wd_act = next_s.wd_flag && !next_s.regs[REG_CONTROL][CTL_WDOG_MASK];
        if (next_s.regs[REG_CONTROL][CTL_IRQ_SWAP]) begin // RQ12
            next_s.irq_a = alarm_act;
            next_s.irq_b = wd_act;
        end else begin
            next_s.irq_a = wd_act;
            next_s.irq_b = alarm_act;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            s <= '0;
            s.bus_st <= BUS_IDLE;
            s.sel_n <= 1'b1;
            s.gate_n <= 1'b1;
            s.strobe_n <= 1'b1;
            s.dout_oe_n <= 1'b1;
            s.regs[REG_CONTROL] <= CTL_RESET;
        end else if (clock_en) begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Memory and pins
    // ------------------------------------------------------------
    assign mem.we = wr_ev && (s.wr_addr >= ADDR_W'(REG_COUNT)); // RQ18
    assign mem.addr = wr_ev ? s.wr_addr : s.addr;
    assign mem.wdata = s.wr_data;

    bnvtp_mem #(.ADDR_W(ADDR_W)) u_mem (
        .clock(clock),
        .clock_en(clock_en),
        .mem(mem.store)
    );

    assign data_pins_out = s.dout;
    assign data_pins_oe_n = s.dout_oe_n;
    // Open drain: only ever pulls low
    assign irq_first_n_out = 1'b0;
    assign irq_first_n_oe_n = !s.irq_a;
    assign irq_second_n_out = 1'b0;
    assign irq_second_n_oe_n = !s.irq_b;
endmodule : bnvtp_top
`default_nettype wire

/* verif/bnvtp_props.sv */
/* Pin-level checks of the timekeeper port.
   Bound into bnvtp_top; sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
module bnvtp_props #(
    parameter int ADDR_BITS = 17
) (
    // Clock, reset, supply
    input wire logic clock,
    input wire logic rst,
    input wire logic clock_en,
    input wire logic supply_ok,
    // Bus
    input wire logic select_n,
    input wire logic output_gate_n,
    input wire logic write_strobe_n,
    input wire logic [ADDR_BITS-1:0] address,
    input wire logic [7:0] data_pins_in,
    input wire logic [7:0] data_pins_out,
    input wire logic data_pins_oe_n,
    // Interrupts
    input wire logic irq_first_n_out,
    input wire logic irq_first_n_oe_n,
    input wire logic irq_second_n_out,
    input wire logic irq_second_n_oe_n
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    wire logic rd_s = !select_n && !output_gate_n && write_strobe_n && supply_ok && clock_en;
    wire logic wr_s = !select_n && !write_strobe_n && clock_en;
    // ------
    // Assertions
    // ------
    AST_READ_DRIVES: assert property (rd_s [*3] |=> !data_pins_oe_n)
        else $error("read not driven");
    AST_READ_RELEASE: assert property ((select_n || output_gate_n) [*3] |=> data_pins_oe_n)
        else $error("drive after read");
    AST_WRITE_OFF: assert property (wr_s [*3] |=> data_pins_oe_n)
        else $error("drive in write");
    AST_SUPPLY_QUIET: assert property ((!supply_ok) [*3] |-> data_pins_oe_n)
        else $error("drive at low supply");
    AST_DRIVE_CAUSE: assert property (!data_pins_oe_n |-> $past(!select_n, 2) && $past(supply_ok, 2))
        else $error("drive without read");
    AST_READ_STEADY: assert property ((rd_s && $stable(address) && address > 'hd) [*5]
        |-> $stable(data_pins_out))
        else $error("read data moved");
    AST_IRQ_DRIVE: assert property (irq_first_n_out == 1'b0 && irq_second_n_out == 1'b0)
        else $error("irq drive not low");
    AST_HOLD_FROZEN: assert property (!clock_en |=> $stable(data_pins_out)
        && $stable(data_pins_oe_n) && $stable(irq_second_n_oe_n))
        else $error("moved while frozen");
    // ------
    // Cover
    // ------
    COV_READ: cover property (rd_s [*4]);
    COV_WRITE: cover property (wr_s [*3] ##1 write_strobe_n);
    COV_WDOG: cover property ($fell(irq_second_n_oe_n));
endmodule : bnvtp_props
bind bnvtp_top bnvtp_props #(.ADDR_BITS(ADDR_BITS)) bnvtp_props_i (
    .clock(clock), .rst(rst), .clock_en(clock_en), .supply_ok(supply_ok),
    .select_n(select_n), .output_gate_n(output_gate_n), .write_strobe_n(write_strobe_n),
    .address(address), .data_pins_in(data_pins_in), .data_pins_out(data_pins_out),
    .data_pins_oe_n(data_pins_oe_n), .irq_first_n_out(irq_first_n_out),
    .irq_first_n_oe_n(irq_first_n_oe_n), .irq_second_n_out(irq_second_n_out),
    .irq_second_n_oe_n(irq_second_n_oe_n));
`default_nettype wire

/* verif/bnvtp_host_model.sv */
/* Host bus model with read and write tasks.
   Tasks run one at a time; the data wire is resolved here. */
`timescale 1ns/100ps
`default_nettype none
module bnvtp_host_model
    import bnvtp_pkg::*;
(
    // Clock and device outputs
    input wire logic clock,
    input wire logic [7:0] data_pins_out,
    input wire logic data_pins_oe_n,
    // Bus
    output var logic select_n,
    output var logic output_gate_n,
    output var logic write_strobe_n,
    output var logic [ADDR_W-1:0] address,
    output logic [7:0] data_pins_in
);
    logic host_oe = 1'b0;
    logic [7:0] drv = 8'h00;
    logic [7:0] last = 8'h00;
    // Undriven bus toggles
    assign data_pins_in = !data_pins_oe_n ? data_pins_out : host_oe ? drv : ~last;
    always @(posedge clock) begin
        last <= data_pins_in;
    end
    initial begin
        select_n = 1'b1;
        output_gate_n = 1'b1;
        write_strobe_n = 1'b1;
        address = '0;
    end
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(negedge clock);
        address = a;
        drv = d;
        host_oe = 1'b1;
        select_n = 1'b0;
        write_strobe_n = 1'b0;
        repeat (3) @(negedge clock);
        write_strobe_n = 1'b1;
        select_n = 1'b1;
        repeat (2) @(negedge clock);
        host_oe = 1'b0;
        @(negedge clock);
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        @(negedge clock);
        address = a;
        select_n = 1'b0;
        output_gate_n = 1'b0;
        repeat (4) @(negedge clock);
        d = data_pins_in;
        select_n = 1'b1;
        output_gate_n = 1'b1;
        repeat (3) @(negedge clock);
    endtask : rd
endmodule : bnvtp_host_model
`default_nettype wire

/* verif/tb.sv */
/* Self-checking bench for the timekeeper port.
   Host model drives the bus; short tick. */
`timescale 1ns/100ps
`default_nettype none
module tb;
    import bnvtp_pkg::*;
    logic clock = 1'b0, rst = 1'b1, clock_en = 1'b1, supply_ok = 1'b1;
    logic select_n, output_gate_n, write_strobe_n;
    logic [ADDR_W-1:0] address;
    logic [7:0] din, dout, d;
    logic oe_n, i1_oe, i2_oe, i1, i2;
    int n_mismatch = 0, num_checks = 0, cyc = 0;
    logic [3:0] m_idx [12] = '{4'h9, 4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h7, 4'h8, 4'ha, 4'h3, 4'h5, 4'hb};
    logic [7:0] m_val [12] = '{8'hdf, 8'hff, 8'h7f, 8'h7f, 8'h7f, 8'h07, 8'h87, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hcc};
    logic [16:0] mem_a [3] = '{17'h0000e, 17'h1000e, 17'h1ffff};
    logic [7:0] mem_d [3] = '{8'h5a, 8'ha5, 8'h3c};
    always #25 clock = ~clock;
    bnvtp_top #(.TICK_LEN(20)) bnvtp_top_i (
        .clock(clock), .rst(rst), .clock_en(clock_en), .supply_ok(supply_ok),
        .select_n(select_n), .output_gate_n(output_gate_n), .write_strobe_n(write_strobe_n),
        .address(address), .data_pins_in(din), .data_pins_out(dout), .data_pins_oe_n(oe_n),
        .irq_first_n_out(i1), .irq_first_n_oe_n(i1_oe), .irq_second_n_out(i2),
        .irq_second_n_oe_n(i2_oe));
    bnvtp_host_model bnvtp_host_model_i (
        .clock(clock), .data_pins_out(dout), .data_pins_oe_n(oe_n), .select_n(select_n),
        .output_gate_n(output_gate_n), .write_strobe_n(write_strobe_n),
        .address(address), .data_pins_in(din));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic rchk(input logic [16:0] a, input logic [7:0] exp, input string what);
        bnvtp_host_model_i.rd(a, d);
        chk(what, exp, d);
    endtask : rchk
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            conclude();
        end
    end
    initial begin
        repeat (4) @(posedge clock);
        @(negedge clock) rst = 1'b0;
        rchk(17'hb, CTL_RESET, "control reset");
        for (int i = 2; i < 14; i++) begin
            if (i != 11) rchk(17'(i), 8'h00, "reg reset");
        end
        $display("test reset done");
        bnvtp_host_model_i.wr(17'hb, 8'h40);
        bnvtp_host_model_i.wr(17'h0, 8'h25);
        repeat (100) @(negedge clock);
        rchk(17'h0, 8'h25, "frozen hundredths");
        bnvtp_host_model_i.wr(17'hb, 8'hc0);
        repeat (100) @(negedge clock);
        bnvtp_host_model_i.rd(17'h0, d);
        num_checks++;
        if (d === 8'h25 || ^d === 1'bx) begin
            n_mismatch++;
            $display("[FAIL] hundredths expected change seen %h", d);
        end
        $display("test transfer done");
        bnvtp_host_model_i.wr(17'hb, 8'h40);
        for (int i = 0; i < 12; i++) begin
            bnvtp_host_model_i.wr(17'(m_idx[i]), 8'hff);
            rchk(17'(m_idx[i]), m_val[i], "wmask");
        end
        bnvtp_host_model_i.wr(17'hb, 8'h40);
        bnvtp_host_model_i.wr(17'h9, 8'h00);
        $display("test masks done");
        for (int i = 0; i < 3; i++) bnvtp_host_model_i.wr(mem_a[i], mem_d[i]);
        for (int i = 0; i < 3; i++) rchk(mem_a[i], mem_d[i], "user byte");
        $display("test memory done");
        @(negedge clock) supply_ok = 1'b0;
        bnvtp_host_model_i.wr(17'he, 8'h00);
        fork
            bnvtp_host_model_i.rd(17'he, d);
            begin
                repeat (5) @(negedge clock);
                chk("oe supply low", 8'h01, {7'h00, oe_n});
            end
        join
        @(negedge clock) clock_en = 1'b0;
        repeat (5) @(negedge clock);
        clock_en = 1'b1;
        supply_ok = 1'b1;
        repeat (10) @(negedge clock);
        rchk(17'he, 8'h5a, "byte kept");
        $display("test supply done");
        bnvtp_host_model_i.wr(17'hc, 8'h05);
        bnvtp_host_model_i.wr(17'hd, 8'h00);
        @(negedge clock) supply_ok = 1'b0;
        repeat (200) @(negedge clock);
        chk("watchdog irq", 8'h00, {7'h00, i2_oe});
        chk("alarm irq idle", 8'h01, {7'h00, i1_oe});
        supply_ok = 1'b1;
        repeat (10) @(negedge clock);
        rchk(17'hb, 8'h42, "watchdog flag");
        rchk(17'hc, 8'h05, "watchdog interval");
        chk("irq cleared", 8'h01, {7'h00, i2_oe});
        bnvtp_host_model_i.wr(17'hc, 8'h00);
        repeat (200) @(negedge clock);
        chk("watchdog disabled", 8'h01, {7'h00, i2_oe});
        $display("test watchdog done");
        conclude();
    end
endmodule : tb
`default_nettype wire
